//--- verilog/fwp_pkg.sv
/*
 feature_write_protection package: feature addresses, field positions, reset values,
 command codes and shared functions for the serial flash feature-register block.
 assumes: one 40 MHz system clock; the serial link is sampled, not clocked on.
*/
// Operation
// - lock settings holds guard(7), range code(6:3), bottom(2), hw select(1), persist(0).
// - all lock settings bits are volatile and host writable unless locked.
// - guard=1 with write-guard pin low refuses range code and bottom changes.
// - persistent lock=1 freezes range, bottom and hw select until power cycle.
// - hw select 0 is default; software mode, guard and pause pins are data.
// - hw select 1 is hardware mode; four-line data off, pins are control inputs.
// - software mode with all three bits 0: pin has no protection role.
// - software mode, guard 1, persist 0: pin low blocks, pin high allows changes.
// - software mode, persist 1, guard 0: settings locked until power cycle.
// - software mode, persist and guard 1: locked, settings fuse may be set.
// - hardware mode, persist 1, pin high: locked; fuse settable when guard 1.
// - hardware mode with pin low: every write blocked, everything read-only.
// - power cycle returns persistent lock and guard to 0.
// - registers sit at feature addresses a0h, b0h, c0h and d0h.
// - get-feature reads, set-feature writes; one address byte, one data byte.
// - after power-on all four range code bits are 1.
// - program or erase aimed at a protected block is ignored.
package fwp_pkg;
	// ----------------------------------------
	// command codes and feature addresses
	// ----------------------------------------
	localparam logic [7:0] OP_GET_FEATURE = 8'h0f;
	localparam logic [7:0] OP_SET_FEATURE = 8'h1f;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] ADDR_LOCK = 8'ha0;
	localparam logic [7:0] ADDR_CONFIG = 8'hb0;
	localparam logic [7:0] ADDR_STATUS = 8'hc0;
	localparam logic [7:0] ADDR_DRIVE = 8'hd0;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int LOCK_GUARD_BIT = 7;
	localparam int LOCK_RANGE_MSB = 6;
	localparam int LOCK_RANGE_LSB = 3;
	localparam int LOCK_BOTTOM_BIT = 2;
	localparam int LOCK_HWSEL_BIT = 1;
	localparam int LOCK_PERSIST_BIT = 0;
	localparam int CFG_FUSE_BIT = 5;
	// ----------------------------------------
	// reset values and write masks
	// ----------------------------------------
	localparam logic [7:0] LOCK_RESET = 8'h7c;
	localparam logic [7:0] CONFIG_RESET = 8'h10;
	localparam logic [7:0] DRIVE_RESET = 8'h00;
	localparam logic [7:0] CONFIG_WMASK = 8'hd1;
	localparam logic [7:0] DRIVE_WMASK = 8'h60;
	localparam logic [7:0] ALL_BITS = 8'hff;
	localparam logic [7:0] NO_BITS = 8'h00;
	// ----------------------------------------
	// array geometry
	// ----------------------------------------
	localparam int BLK_W = 11;
	localparam logic [11:0] BLK_COUNT = 12'h800;
	localparam logic [3:0] RANGE_LARGEST = 4'ha;
	// ----------------------------------------
	// link timing (bench figure only)
	// ----------------------------------------
	localparam int LINK_PERIOD_NS = 200;
	localparam int CLK_PERIOD_NS = 25;
	localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

	// masked update of a feature register
	function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	// block inside the range selected by code and bottom flag
	function automatic logic in_range(input logic [3:0] code, input logic bottom,
		input logic [BLK_W-1:0] blk);
		logic [11:0] size;
		size = 12'h001 << code;
		if (code == 4'h0) begin
			in_range = 1'b0;
		end else if (code > RANGE_LARGEST) begin
			in_range = 1'b1;
		end else if (bottom) begin
			in_range = {1'b0, blk} < size;
		end else begin
			in_range = {1'b0, blk} >= (BLK_COUNT - size);
		end
	endfunction
endpackage

//--- verilog/fwp_link_if.sv
/*
 fwp_link_if: sampled serial link events passed from the link front end to the core.
 assumes: all signals are on clk_i; front end has already synchronised the pins.
*/
`timescale 1ns/1ps
interface fwp_link_if;
	logic frame_active;
	logic sck_fall;
	logic byte_stb;
	logic [7:0] rx_byte;
	logic wp_level;
	modport front (output frame_active, output sck_fall, output byte_stb, output rx_byte,
		output wp_level);
	modport core (input frame_active, input sck_fall, input byte_stb, input rx_byte,
		input wp_level);
endinterface

//--- verilog/fwp_link_rx.sv
/*
 fwp_link_rx: synchronises the serial pins, finds clock edges and assembles bytes.
 assumes: link clock far slower than clk_i; select, clock, data and pause are pins.
*/
`timescale 1ns/1ps
module fwp_link_rx (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	input wire logic wp_i,
	input wire logic hold_n_i,
	input wire logic pause_en_i,
	fwp_link_if.front link
);
	import fwp_pkg::*;

	// ----------------------------------------
	// two-flop synchronisers
	// ----------------------------------------
	logic [4:0] meta_q;
	logic [4:0] sync_q;
	logic sck_last_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic paused;
	logic rise;
	logic fall;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_q <= 5'h1c;
			sync_q <= 5'h1c;
			sck_last_q <= 1'b0;
		end else begin
			meta_q <= {hold_n_i, cs_n_i, wp_i, si_i, sck_i};
			sync_q <= meta_q;
			sck_last_q <= sync_q[0];
		end
	end

	// pause pin acts as control input only when pause_en_i (hardware mode) is set
	assign paused = pause_en_i & ~sync_q[4];
	assign rise = ~sync_q[3] & ~paused & sync_q[0] & ~sck_last_q;
	assign fall = ~sync_q[3] & ~paused & ~sync_q[0] & sck_last_q;

	// ----------------------------------------
	// byte assembly
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i || sync_q[3]) begin
			bit_cnt_q <= 3'h0;
			shift_q <= 8'h00;
		end else if (rise) begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			shift_q <= {shift_q[6:0], sync_q[1]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			link.byte_stb <= 1'b0;
			link.rx_byte <= 8'h00;
			link.sck_fall <= 1'b0;
			link.frame_active <= 1'b0;
			link.wp_level <= 1'b1;
		end else begin
			link.byte_stb <= rise & (bit_cnt_q == 3'h7);
			link.rx_byte <= {shift_q[6:0], sync_q[1]};
			link.sck_fall <= fall;
			link.frame_active <= ~sync_q[3];
			link.wp_level <= sync_q[2];
		end
	end
endmodule // fwp_link_rx

//--- verilog/fwp_guard.sv
/*
 fwp_guard: decides which feature bits a set-feature may change right now.
 assumes: inputs come from registers on the same clock; purely combinational.
*/
`timescale 1ns/1ps
module fwp_guard (
	input wire logic [7:0] lock_i,
	input wire logic fuse_i,
	input wire logic wp_level_i,
	output logic [7:0] lock_mask_o,
	output logic [7:0] config_mask_o,
	output logic [7:0] drive_mask_o,
	output logic fuse_ok_o,
	output logic hw_block_o
);
	import fwp_pkg::*;

	logic guard;
	logic hw_sel;
	logic persist;

	assign guard = lock_i[LOCK_GUARD_BIT];
	assign hw_sel = lock_i[LOCK_HWSEL_BIT];
	assign persist = lock_i[LOCK_PERSIST_BIT];
	assign hw_block_o = hw_sel & ~wp_level_i;

	always_comb begin
		lock_mask_o = ALL_BITS;
		config_mask_o = CONFIG_WMASK;
		drive_mask_o = DRIVE_WMASK;
		if (hw_block_o) begin
			lock_mask_o = NO_BITS;
			config_mask_o = NO_BITS;
			drive_mask_o = NO_BITS;
		end else if (persist || fuse_i) begin
			lock_mask_o = NO_BITS;
		end else if (guard && !wp_level_i) begin
			lock_mask_o = NO_BITS;
		end
		// no guard in software mode, pin plays no part
	end

	assign fuse_ok_o = persist & guard & ~hw_block_o;
endmodule // fwp_guard

//--- verilog/fwp_top.sv
/*
 fwp_top: feature-register map and write protection of a serial flash device.
 holds the four feature registers, runs get/set feature over the serial link and
 screens program/erase requests against the protected block range.
 assumes: reset_i is the power-on reset; program/erase requests come from logic on clk_i.
*/
`timescale 1ns/1ps
module fwp_top (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	input wire logic wp_i,
	input wire logic hold_n_i,
	output logic so_o,
	output logic so_oe_o,
	output logic quad_enable_o,
	output logic write_block_o,
	input wire logic busy_i,
	input wire logic [2:0] ecc_state_i,
	input wire logic pe_req_i,
	input wire logic pe_is_erase_i,
	input wire logic [fwp_pkg::BLK_W-1:0] pe_block_i,
	output logic pe_grant_o,
	output logic pe_refuse_o
);
	import fwp_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ADDR = 4'b0010,
		ST_DATA = 4'b0100,
		ST_SKIP = 4'b1000
	} fwp_state_t;

	fwp_link_if link ();

	fwp_state_t state_q;
	fwp_state_t state_d;
	logic is_get_q;
	logic [7:0] addr_q;
	logic [7:0] tx_q;
	logic [7:0] lock_q;
	logic [7:0] config_q;
	logic [7:0] drive_q;
	logic wel_q;
	logic prog_fail_q;
	logic erase_fail_q;
	logic [7:0] lock_mask;
	logic [7:0] config_mask;
	logic [7:0] drive_mask;
	logic fuse_ok;
	logic hw_block;
	logic [7:0] read_value;
	logic [7:0] status_value;
	logic set_done;
	logic pe_protected;

	// ----------------------------------------
	// link front end and guard
	// ----------------------------------------
	fwp_link_rx u_rx (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.sck_i(sck_i),
		.cs_n_i(cs_n_i),
		.si_i(si_i),
		.wp_i(wp_i),
		.hold_n_i(hold_n_i),
		.pause_en_i(lock_q[LOCK_HWSEL_BIT]),
		.link(link.front)
	);

	fwp_guard u_guard (
		.lock_i(lock_q),
		.fuse_i(config_q[CFG_FUSE_BIT]),
		.wp_level_i(link.wp_level),
		.lock_mask_o(lock_mask),
		.config_mask_o(config_mask),
		.drive_mask_o(drive_mask),
		.fuse_ok_o(fuse_ok),
		.hw_block_o(hw_block)
	);

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (link.byte_stb) begin
					// get and set take an address
					if (link.rx_byte == OP_GET_FEATURE || link.rx_byte == OP_SET_FEATURE) begin
						state_d = ST_ADDR;
					end else begin
						state_d = ST_SKIP;
					end
				end
			end
			ST_ADDR: begin
				if (link.byte_stb) begin
					state_d = ST_DATA;
				end
			end
			ST_DATA: begin
				if (link.byte_stb) begin
					state_d = ST_SKIP;
				end
			end
			ST_SKIP: begin
				state_d = ST_SKIP;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (!link.frame_active) begin
			state_d = ST_IDLE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			is_get_q <= 1'b0;
			addr_q <= 8'h00;
		end else if (link.byte_stb && state_q == ST_IDLE) begin
			is_get_q <= (link.rx_byte == OP_GET_FEATURE);
		end else if (link.byte_stb && state_q == ST_ADDR) begin
			addr_q <= link.rx_byte;
		end
	end

	assign set_done = link.byte_stb & (state_q == ST_DATA) & ~is_get_q;

	// ----------------------------------------
	// feature register read mux
	// ----------------------------------------
	assign status_value = {1'b0, ecc_state_i, prog_fail_q, erase_fail_q, wel_q, busy_i};

	always_comb begin
		case (link.rx_byte)
			ADDR_LOCK: read_value = lock_q;
			ADDR_CONFIG: read_value = config_q;
			ADDR_STATUS: read_value = status_value;
			ADDR_DRIVE: read_value = drive_q;
			default: read_value = 8'h00;
		endcase
	end

	// ----------------------------------------
	// serial output
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_q <= 8'h00;
			so_o <= 1'b0;
		end else if (link.byte_stb && state_q == ST_ADDR && is_get_q) begin
			tx_q <= read_value;
		end else if (link.sck_fall && state_q == ST_DATA && is_get_q) begin
			so_o <= tx_q[7];
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			so_oe_o <= 1'b0;
		end else begin
			so_oe_o <= (state_d == ST_DATA) & is_get_q;
		end
	end

	// ----------------------------------------
	// block lock settings
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			lock_q <= LOCK_RESET;
		end else if (set_done && addr_q == ADDR_LOCK) begin
			lock_q <= merge(lock_q, link.rx_byte, lock_mask);
		end
	end

	// ----------------------------------------
	// device configuration
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			config_q <= CONFIG_RESET;
		end else if (set_done && addr_q == ADDR_CONFIG) begin
			config_q <= merge(config_q, link.rx_byte, config_mask);
			config_q[CFG_FUSE_BIT] <= config_q[CFG_FUSE_BIT] |
				(link.rx_byte[CFG_FUSE_BIT] & fuse_ok);
		end
	end

	// ----------------------------------------
	// output drive strength
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			drive_q <= DRIVE_RESET;
		end else if (set_done && addr_q == ADDR_DRIVE) begin
			drive_q <= merge(drive_q, link.rx_byte, drive_mask);
		end
	end

	// ----------------------------------------
	// write latch flag
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wel_q <= 1'b0;
		end else if (link.byte_stb && state_q == ST_IDLE) begin
			if (link.rx_byte == OP_WRITE_ENABLE) begin
				wel_q <= 1'b1;
			end else if (link.rx_byte == OP_WRITE_DISABLE) begin
				wel_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// program / erase screening
	// ----------------------------------------
	// protected range lookup
	assign pe_protected = hw_block |
		in_range(lock_q[LOCK_RANGE_MSB:LOCK_RANGE_LSB], lock_q[LOCK_BOTTOM_BIT], pe_block_i);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pe_grant_o <= 1'b0;
			pe_refuse_o <= 1'b0;
		end else begin
			pe_grant_o <= pe_req_i & ~pe_protected;
			pe_refuse_o <= pe_req_i & pe_protected;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			prog_fail_q <= 1'b0;
			erase_fail_q <= 1'b0;
		end else if (pe_req_i) begin
			prog_fail_q <= pe_protected & ~pe_is_erase_i;
			erase_fail_q <= pe_protected & pe_is_erase_i;
		end
	end

	// ----------------------------------------
	// mode outputs
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			quad_enable_o <= 1'b1;
			write_block_o <= 1'b0;
		end else begin
			quad_enable_o <= ~lock_q[LOCK_HWSEL_BIT];
			write_block_o <= hw_block;
		end
	end
endmodule // fwp_top

//--- tb/fwp_host_model.sv
/*
 fwp_host_model: serial host issuing get/set feature frames in mode 0.
 assumes: link clock 200 ns, free of the system clock; idle clock low.
*/
`timescale 1ns/1ps
module fwp_host_model (
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	// --------------------
	// frame task
	// --------------------
	// op, address, one data byte
	task automatic xfer(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] wd,
		output logic [7:0] rd);
		logic [23:0] sh;
		sh = {op, adr, wd};
		rd = 8'h00;
		#7 cs_n_o = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			si_o = sh[i];
			#100 sck_o = 1'b1;
			#90 if (i < 8) rd[i] = so_i;
			#10 sck_o = 1'b0;
		end
		#100 cs_n_o = 1'b1;
		si_o = ~si_o;
		// deselect gap, several system clocks
		#200;
	endtask
endmodule // fwp_host_model

//--- tb/fwp_top_assertions.sv
/*
 fwp_top_checker: port-level properties of fwp_top, bound into it.
 assumes: one clock clk_i, synchronous reset_i.
*/
`timescale 1ns/1ps
module fwp_top_checker (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic cs_n_i,
	input wire logic wp_i,
	input wire logic pe_req_i,
	input logic so_oe_o,
	input logic quad_enable_o,
	input logic write_block_o,
	input logic pe_grant_o,
	input logic pe_refuse_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// --------------------
	// properties
	// --------------------
	AST_RST_OUT: assert property ($fell(reset_i) |-> quad_enable_o && !so_oe_o
		&& !write_block_o && !pe_grant_o && !pe_refuse_o) else $error("outputs not idle");
	AST_PE_ONE: assert property (pe_req_i |=> pe_grant_o != pe_refuse_o)
		else $error("request without one answer");
	AST_PE_IDLE: assert property (!pe_req_i |=> !pe_grant_o && !pe_refuse_o)
		else $error("answer without request");
	AST_HW_REFUSE: assert property (pe_req_i && write_block_o |=> pe_refuse_o)
		else $error("request granted while blocked");
	AST_QUAD_WB: assert property (write_block_o |-> !quad_enable_o)
		else $error("four-line data on in hardware mode");
	AST_WB_HIGH: assert property (wp_i [*5] |-> !write_block_o)
		else $error("blocked with pin high");
	AST_WB_LOW: assert property ((!wp_i && !quad_enable_o) [*6] |-> write_block_o)
		else $error("not blocked with pin low");
	AST_OE_CS: assert property (cs_n_i [*6] |-> !so_oe_o)
		else $error("output driven while deselected");
	AST_QUAD_FRAME: assert property ($changed(quad_enable_o) |-> !$past(cs_n_i, 3))
		else $error("mode changed outside a frame");
endmodule // fwp_top_checker

bind fwp_top fwp_top_checker fwp_top_checker_i (.clk_i, .reset_i, .cs_n_i, .wp_i,
	.pe_req_i, .so_oe_o, .quad_enable_o, .write_block_o, .pe_grant_o, .pe_refuse_o);

//--- tb/tb_top.sv
/*
 tb_top: self-checking bench, register model compared at every read.
 assumes: fwp_pkg, design, host model and checker compiled first.
*/
`timescale 1ns/1ps
module tb_top;
	import fwp_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic wp_i = 1'b1;
	logic busy_i = 1'b0;
	logic [2:0] ecc_state_i = 3'h0;
	logic pe_req_i = 1'b0;
	logic pe_is_erase_i = 1'b0;
	logic [BLK_W-1:0] pe_block_i = 11'h000;
	logic sck_i, cs_n_i, si_i, so_o, so_oe_o, quad_enable_o, write_block_o;
	logic pe_grant_o, pe_refuse_o, pf_m, ef_m, wel_m;
	logic [7:0] lock_m, cfg_m, drv_m, rd;
	logic [31:0] r;
	int fail_count = 0;
	int n_tests = 0;
	int seed = 32'hc444;
	logic [7:0] adr [5] = '{ADDR_LOCK, ADDR_CONFIG, ADDR_STATUS, ADDR_DRIVE, 8'h55};
	logic [16:0] stp [16] = '{17'h1d0ff, 17'h0a000, 17'h1a080, 17'h0a008, 17'h1a088,
		17'h1a08a, 17'h0d000, 17'h1b020, 17'h1a08b, 17'h1a000, 17'h1b0ff, 17'h10000,
		17'h0a001, 17'h1a07c, 17'h1b020, 17'h0a080};

	always #12.5 clk_i = ~clk_i;

	fwp_top fwp_top_i (.clk_i, .reset_i, .sck_i, .cs_n_i, .si_i, .wp_i, .hold_n_i(1'b1),
		.so_o, .so_oe_o, .quad_enable_o, .write_block_o, .busy_i, .ecc_state_i, .pe_req_i,
		.pe_is_erase_i, .pe_block_i, .pe_grant_o, .pe_refuse_o);
	fwp_host_model fwp_host_model_i (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o));

	// --------------------
	// tasks
	// --------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic do_reset;
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		lock_m = 8'h7c;
		cfg_m = 8'h10;
		drv_m = 8'h00;
		pf_m = 1'b0;
		ef_m = 1'b0;
		wel_m = 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic mset(input logic [7:0] a, input logic [7:0] d);
		logic hb;
		hb = lock_m[1] & ~wp_i;
		fwp_host_model_i.xfer(OP_SET_FEATURE, a, d, rd);
		if (a == ADDR_LOCK && !(lock_m[0] | cfg_m[5] | (lock_m[7] & ~wp_i) | hb))
			lock_m = d;
		if (a == ADDR_CONFIG && !hb)
			cfg_m = (cfg_m & ~CONFIG_WMASK) | (d & CONFIG_WMASK)
				| (d & 8'h20 & {8{lock_m[0] & lock_m[7]}});
		if (a == ADDR_DRIVE && !hb)
			drv_m = (drv_m & ~DRIVE_WMASK) | (d & DRIVE_WMASK);
	endtask

	task automatic mchk(input logic [7:0] a);
		logic [7:0] e;
		fwp_host_model_i.xfer(OP_GET_FEATURE, a, 8'h00, rd);
		e = a == ADDR_LOCK ? lock_m : a == ADDR_CONFIG ? cfg_m : a == ADDR_DRIVE ? drv_m
			: a == ADDR_STATUS ? {1'b0, ecc_state_i, pf_m, ef_m, wel_m, busy_i} : 8'h00;
		chk(rd, e);
	endtask

	task automatic pe(input logic [10:0] b, input logic er);
		logic [11:0] sz;
		logic [3:0] c;
		logic ex;
		c = lock_m[6:3];
		sz = 12'h001 << c;
		ex = (lock_m[1] & ~wp_i) | (c > 4'ha)
			| (c != 4'h0 && (lock_m[2] ? {1'b0, b} < sz : {1'b0, b} >= 12'h800 - sz));
		@(posedge clk_i);
		pe_req_i <= 1'b1;
		pe_block_i <= b;
		pe_is_erase_i <= er;
		@(posedge clk_i);
		pe_req_i <= 1'b0;
		#1;
		chk({6'h0, pe_grant_o, pe_refuse_o}, {6'h0, ~ex, ex});
		pf_m = ex & ~er;
		ef_m = ex & er;
	endtask

	// --------------------
	// sequence
	// --------------------
	initial begin
		repeat (90000) @(posedge clk_i);
		fail_count++;
		final_report;
	end

	initial begin
		do_reset;
		foreach (adr[k]) mchk(adr[k]);
		chk({6'h0, quad_enable_o, write_block_o}, 8'h02);
		fwp_host_model_i.xfer(OP_WRITE_ENABLE, 8'h00, 8'h00, rd);
		wel_m = 1'b1;
		mchk(ADDR_STATUS);
		fwp_host_model_i.xfer(OP_WRITE_DISABLE, 8'h00, 8'h00, rd);
		wel_m = 1'b0;
		mchk(ADDR_STATUS);
		$display("test reset_values done");
		for (int i = 0; i < 12; i++) begin
			r = $random(seed);
			@(posedge clk_i);
			busy_i <= r[12];
			ecc_state_i <= r[15:13];
			mset(ADDR_LOCK, {1'b0, i[3:0], r[0], 2'b00});
			pe(r[26:16], r[1]);
			pe(11'h7ff, 1'b0);
			pe(11'h000, 1'b1);
			mchk(ADDR_STATUS);
		end
		$display("test range_sweep done");
		foreach (stp[k]) begin
			@(posedge clk_i);
			wp_i <= stp[k][16];
			repeat (8) @(posedge clk_i);
			if (stp[k][15:8] == 8'h00)
				do_reset;
			else
				mset(stp[k][15:8], stp[k][7:0]);
			foreach (adr[j]) mchk(adr[j]);
			r = $random(seed);
			pe(r[10:0], r[11]);
			chk({6'h0, quad_enable_o, write_block_o}, {6'h0, ~lock_m[1], lock_m[1] & ~wp_i});
		end
		$display("test protection_table done");
		final_report;
	end
endmodule // tb_top
